//--- verilog/main_clock_select_prescale.v
/*
 * Main clock control: source select with pending switch, prescaler,
 * peripheral clock pin, one-way lock, status and oscillator registers
 * on an AHB-Lite slave (byte registers, one per word).
 * Assumes oscillators report raw stability and clock edges as pulses
 * synchronous to ref_clk_i, and the CPU flags the protection window.
 */
// Decided for this implementation: the AHB-Lite register port.
// Notes on behaviour
// RULE1: With pin output enable set, the peripheral clock drives the clock pin.
// RULE2: The pin toggles only while the peripheral clock runs.
// RULE3: Source select 0..3 picks high-frequency, low-power, crystal or pin clock.
// RULE4: With prescaler enabled, ratio codes give divides 2..64 and 6..48.
// RULE5: Ratio may be rewritten while running and takes effect without reset.
// RULE6: Software keeps the peripheral clock below its allowed maximum.
// RULE7: Prescaler disabled passes main clock undivided, whatever the ratio.
// RULE8: Lock blocks writes to control A, B and current source calibration.
// RULE9: Once locked, lock register is inaccessible until hardware reset.
// RULE10: Stable flags show only for sources requested by main clock or peripheral.
// RULE11: Run-in-standby alone never makes a stable flag read one.
// RULE12: Status bits 5..1 report PLL, pin, crystal, low-power, high-frequency stable.
// RULE13: Switch pending flag stays set until new source is stable, then moves.
// RULE14: Protected registers accept writes only inside the unlock window.
// RULE15: Reserved select or ratio codes are ignored, old setting stays.
// RULE16: Status bits 7..6 and reserved offsets read zero, writes ignored.
`timescale 1ns/1ns
`include "main_clock_consts.vh"

module main_clock_select_prescale (
	// Clock and reset
	input wire ref_clk_i,
	input wire rst_n_i,
	// AHB-Lite slave
	input wire hsel_i,
	input wire [7:0] haddr_i,
	input wire [1:0] htrans_i,
	input wire hwrite_i,
	input wire [2:0] hsize_i,
	input wire [31:0] hwdata_i,
	input wire hready_i,
	output reg [31:0] hrdata_o,
	output reg hreadyout_o,
	output reg hresp_o,
	// Protection window from the CPU key logic
	input wire ccp_unlock_i,
	// Oscillators: edge pulses per source, raw stability, peripheral requests
	input wire [3:0] source_edge_i,
	input wire [4:0] osc_stable_i,
	input wire [4:0] periph_request_i,
	// Clock outputs
	output reg [4:0] osc_request_o,
	output reg [3:0] main_source_o,
	output reg peripheral_clock_o,
	output reg periph_edge_o,
	output reg clock_pin_o,
	// Oscillator settings
	output reg [7:0] hf_osc_control_a_o,
	output reg [7:0] hf_osc_freq_tune_o,
	output reg [7:0] pll_control_a_o,
	output reg [7:0] lp_osc_control_a_o,
	output reg [7:0] crystal_osc_control_a_o
);

	// Register state
	reg periph_clock_pin_output_en_q;
	reg [3:0] main_source_select_q;
	reg [3:0] prescale_ratio_q;
	reg prescale_enable_q;
	reg main_config_lock_q;
	reg [3:0] active_source_q;
	reg [7:0] status_q;

	// Bus data phase state
	reg wr_pend_q;
	reg [4:0] wr_idx_q;

	wire addr_phase;
	wire [4:0] req_idx;
	wire [7:0] wbyte;
	wire wr_ok;
	wire [4:0] requested;
	wire [4:0] stable_seen;
	wire switch_pending;
	wire main_edge;
	wire div_level;
	wire div_edge;
	wire cal_locked_hf;
	wire cal_locked_xtal;
	reg [7:0] rd_byte;
	wire in_range;
	wire [4:0] standby_req;
	wire [7:0] status_d;

	// Reset images of the control registers, split into their fields
	localparam [7:0] CTRL_A_RST = `RST_MAIN_CTRL_A;
	localparam [7:0] CTRL_B_RST = `RST_MAIN_CTRL_B;

	// Registers gated by the protection key
	function is_protected;
		input [4:0] idx;
		begin
			is_protected = (idx != `IDX_HF_TUNE);
		end
	endfunction

	function valid_select;
		input [3:0] code;
		begin
			valid_select = (code <= `SRC_PIN);
		end
	endfunction

	function valid_ratio;
		input [3:0] code;
		begin
			valid_ratio = (code <= `DIV64) || ((code >= `DIV6) && (code <= `DIV48));
		end
	endfunction

	// Word accesses only; byte index from address bits 6:2
	// Upper address half is unmapped; folding it in would alias registers
	assign in_range = !haddr_i[7];
	assign addr_phase = hsel_i && htrans_i[`HTRANS_NONSEQ_BIT] && hready_i &&
		in_range; // [RULE16]
	assign req_idx = haddr_i[6:2];
	assign wbyte = hwdata_i[7:0];
	assign wr_ok = wr_pend_q && (!is_protected(wr_idx_q) || ccp_unlock_i); // [RULE14]

	// Calibration of the running source follows the lock
	assign cal_locked_hf = main_config_lock_q && (active_source_q == `SRC_HF); // [RULE8]
	assign cal_locked_xtal = main_config_lock_q && (active_source_q == `SRC_XTAL); // [RULE8]

	// Main clock asks for both the running and the wanted source during a switch
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_src_req
			localparam [3:0] SRC_CODE = g;
			assign requested[g] = periph_request_i[g] ||
				(active_source_q == SRC_CODE) || (main_source_select_q == SRC_CODE);
		end
	endgenerate
	assign requested[`OSC_PLL] = periph_request_i[`OSC_PLL];

	// Standby bits start oscillators but never count as a request
	assign stable_seen = osc_stable_i & requested; // [RULE10] [RULE11]
	assign switch_pending = (active_source_q != main_source_select_q);
	assign main_edge = source_edge_i[active_source_q[1:0]];

	// Standby bits keep an oscillator running; the pin clock has no such bit
	assign standby_req[0] = hf_osc_control_a_o[`POS_RUN_STANDBY];
	assign standby_req[1] = lp_osc_control_a_o[`POS_RUN_STANDBY];
	assign standby_req[2] = crystal_osc_control_a_o[`POS_RUN_STANDBY];
	assign standby_req[3] = 1'b0;
	assign standby_req[`OSC_PLL] = pll_control_a_o[`POS_RUN_STANDBY];

	// Status word: bits 7..6 stay zero
	assign status_d = {2'b00, stable_seen[`OSC_PLL], stable_seen[3:0],
		switch_pending}; // [RULE12] [RULE16]

	periph_clock_divider periph_clock_divider_inst (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.main_edge_i(main_edge),
		.prescale_enable_i(prescale_enable_q),
		.prescale_ratio_i(prescale_ratio_q),
		.periph_level_o(div_level),
		.periph_edge_o(div_edge)
	);

	// Read mux, sampled in the address phase
	always @* begin
		rd_byte = 8'h00;
		if (req_idx == `IDX_MAIN_CTRL_A) begin
			rd_byte = {periph_clock_pin_output_en_q, 3'h0, main_source_select_q};
		end else if (req_idx == `IDX_MAIN_CTRL_B) begin
			rd_byte = {3'h0, prescale_ratio_q, prescale_enable_q};
		end else if (req_idx == `IDX_MAIN_LOCK) begin
			// Lock register reads zero whether locked or not
			rd_byte = main_config_lock_q ? 8'h00 : 8'h00; // [RULE9]
		end else if (req_idx == `IDX_MAIN_STATUS) begin
			rd_byte = status_q;
		end else if (req_idx == `IDX_HF_CTRL_A) begin
			rd_byte = hf_osc_control_a_o;
		end else if (req_idx == `IDX_HF_TUNE) begin
			rd_byte = hf_osc_freq_tune_o;
		end else if (req_idx == `IDX_PLL_CTRL_A) begin
			rd_byte = pll_control_a_o;
		end else if (req_idx == `IDX_LP_CTRL_A) begin
			rd_byte = lp_osc_control_a_o;
		end else if (req_idx == `IDX_XTAL_CTRL_A) begin
			rd_byte = crystal_osc_control_a_o;
		end else begin
			rd_byte = 8'h00; // [RULE16]
		end
	end

	// Bus slave: zero wait states, always OKAY
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_pend_q <= 1'b0;
			wr_idx_q <= 5'h00;
			hrdata_o <= 32'h00000000;
			hreadyout_o <= 1'b1;
			hresp_o <= `HRESP_OKAY;
		end else begin
			hreadyout_o <= 1'b1;
			hresp_o <= `HRESP_OKAY;
			wr_pend_q <= addr_phase && hwrite_i;
			if (addr_phase) begin
				wr_idx_q <= req_idx;
			end
			if (addr_phase && !hwrite_i) begin
				hrdata_o <= {24'h000000, rd_byte};
			end else begin
				hrdata_o <= 32'h00000000;
			end
		end
	end

	// Main control and lock registers
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			periph_clock_pin_output_en_q <= CTRL_A_RST[`POS_PIN_OUT_EN];
			main_source_select_q <= CTRL_A_RST[3:0];
			prescale_enable_q <= CTRL_B_RST[`POS_PRESCALE_EN];
			prescale_ratio_q <= CTRL_B_RST[4:1];
			main_config_lock_q <= 1'b0;
		end else if (wr_ok) begin
			if (wr_idx_q == `IDX_MAIN_CTRL_A && !main_config_lock_q) begin // [RULE8]
				periph_clock_pin_output_en_q <= wbyte[`POS_PIN_OUT_EN];
				if (valid_select(wbyte[3:0])) begin // [RULE15]
					main_source_select_q <= wbyte[3:0]; // [RULE3]
				end
			end else if (wr_idx_q == `IDX_MAIN_CTRL_B && !main_config_lock_q) begin // [RULE8]
				prescale_enable_q <= wbyte[`POS_PRESCALE_EN];
				if (valid_ratio(wbyte[4:1])) begin // [RULE15]
					prescale_ratio_q <= wbyte[4:1]; // [RULE5]
				end
			end else if (wr_idx_q == `IDX_MAIN_LOCK && !main_config_lock_q) begin
				// Only reset clears it; no write path back to zero
				if (wbyte[`POS_LOCK]) begin
					main_config_lock_q <= 1'b1; // [RULE9]
				end
			end
		end
	end

	// Oscillator registers; tune is not key protected
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hf_osc_control_a_o <= `RST_HF_CTRL_A;
			hf_osc_freq_tune_o <= `RST_HF_TUNE;
			pll_control_a_o <= `RST_PLL_CTRL_A;
			lp_osc_control_a_o <= `RST_LP_CTRL_A;
			crystal_osc_control_a_o <= `RST_XTAL_CTRL_A;
		end else if (wr_ok) begin
			if (wr_idx_q == `IDX_HF_CTRL_A && !cal_locked_hf) begin // [RULE8]
				hf_osc_control_a_o <= wbyte & `MASK_HF_CTRL_A;
			end else if (wr_idx_q == `IDX_HF_TUNE && !cal_locked_hf) begin // [RULE8]
				// Six-bit signed value; the sign is mirrored into the top bits
				hf_osc_freq_tune_o <= {{2{wbyte[`POS_TUNE_SIGN]}}, wbyte[5:0]};
			end else if (wr_idx_q == `IDX_PLL_CTRL_A) begin
				pll_control_a_o <= wbyte & `MASK_PLL_CTRL_A;
			end else if (wr_idx_q == `IDX_LP_CTRL_A) begin
				lp_osc_control_a_o <= wbyte & `MASK_LP_CTRL_A;
			end else if (wr_idx_q == `IDX_XTAL_CTRL_A && !cal_locked_xtal) begin // [RULE8]
				crystal_osc_control_a_o <= wbyte & `MASK_XTAL_CTRL_A;
			end
		end
	end

	// Source switch: hold the old source until the new one reports stable
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			active_source_q <= `SRC_HF;
			status_q <= 8'h00;
			osc_request_o <= 5'h00;
			main_source_o <= `SRC_HF;
		end else begin
			if (switch_pending && stable_seen[main_source_select_q[1:0]]) begin
				active_source_q <= main_source_select_q; // [RULE13]
			end
			main_source_o <= active_source_q;
			// Status lags the oscillators by one cycle, bits 7..6 stay zero
			status_q <= status_d; // [RULE13]
			osc_request_o <= requested | standby_req;
		end
	end

	// Peripheral clock and its pin
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			peripheral_clock_o <= 1'b0;
			periph_edge_o <= 1'b0;
			clock_pin_o <= 1'b0;
		end else begin
			peripheral_clock_o <= div_level;
			periph_edge_o <= div_edge;
			// Pin follows the divided level, so a stopped clock freezes it
			if (periph_clock_pin_output_en_q) begin
				clock_pin_o <= div_level; // [RULE1] [RULE2]
			end else begin
				clock_pin_o <= 1'b0;
			end
		end
	end

endmodule

//--- verilog/main_clock_consts.vh
/*
 * Constants for the main clock select and prescale block: register indices,
 * field positions, reset values and encodings.
 * Assumes inclusion by bare name from the design files only.
 */
`ifndef MAIN_CLOCK_CONSTS_VH
`define MAIN_CLOCK_CONSTS_VH

// Register indices; byte address on the bus is four times the index
`define IDX_MAIN_CTRL_A 5'h00
`define IDX_MAIN_CTRL_B 5'h01
`define IDX_MAIN_LOCK 5'h02
`define IDX_MAIN_STATUS 5'h03
`define IDX_HF_CTRL_A 5'h08
`define IDX_HF_TUNE 5'h09
`define IDX_PLL_CTRL_A 5'h10
`define IDX_LP_CTRL_A 5'h18
`define IDX_XTAL_CTRL_A 5'h1C

// Reset values
`define RST_MAIN_CTRL_A 8'h00
`define RST_MAIN_CTRL_B 8'h00
`define RST_HF_CTRL_A 8'h0C
`define RST_HF_TUNE 8'h00
`define RST_PLL_CTRL_A 8'h00
`define RST_LP_CTRL_A 8'h00
`define RST_XTAL_CTRL_A 8'h00

// Writable bit masks of the oscillator registers
`define MASK_HF_CTRL_A 8'hBD
`define MASK_PLL_CTRL_A 8'hC3
`define MASK_LP_CTRL_A 8'h80
`define MASK_XTAL_CTRL_A 8'hB7

// Field positions
`define POS_PIN_OUT_EN 7
`define POS_RUN_STANDBY 7
`define POS_LOCK 0
`define POS_PRESCALE_EN 0
`define POS_TUNE_SIGN 5

// Source select codes; bit order of oscillator vectors follows them, PLL last
`define SRC_HF 4'h0
`define SRC_LP 4'h1
`define SRC_XTAL 4'h2
`define SRC_PIN 4'h3
`define OSC_PLL 4

// Prescale ratio codes
`define DIV2 4'h0
`define DIV4 4'h1
`define DIV8 4'h2
`define DIV16 4'h3
`define DIV32 4'h4
`define DIV64 4'h5
`define DIV6 4'h8
`define DIV10 4'h9
`define DIV12 4'hA
`define DIV24 4'hB
`define DIV48 4'hC

// AHB encodings
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY 1'h0

`endif

//--- verilog/periph_clock_divider.v
/*
 * Prescaler that forms the peripheral clock from main clock edges.
 * Assumes main_edge_i pulses once per main clock edge (both edges),
 * synchronous to ref_clk_i; a stopped main clock gives no pulses.
 */
`timescale 1ns/1ns
`include "main_clock_consts.vh"

module periph_clock_divider (
	// Clock and reset
	input wire ref_clk_i,
	input wire rst_n_i,
	// Control
	input wire main_edge_i,
	input wire prescale_enable_i,
	input wire [3:0] prescale_ratio_i,
	// Peripheral clock
	output reg periph_level_o,
	output reg periph_edge_o
);

	reg [6:0] edge_cnt_q;
	wire [6:0] limit;
	wire hit;

	// Main edges per peripheral half period equal the division ratio
	function [6:0] ratio_of;
		input [3:0] code;
		begin
			case (code)
				`DIV2: ratio_of = 7'h02;
				`DIV4: ratio_of = 7'h04;
				`DIV8: ratio_of = 7'h08;
				`DIV16: ratio_of = 7'h10;
				`DIV32: ratio_of = 7'h20;
				`DIV64: ratio_of = 7'h40;
				`DIV6: ratio_of = 7'h06;
				`DIV10: ratio_of = 7'h0A;
				`DIV12: ratio_of = 7'h0C;
				`DIV24: ratio_of = 7'h18;
				`DIV48: ratio_of = 7'h30;
				default: ratio_of = 7'h01;
			endcase
		end
	endfunction

	assign limit = prescale_enable_i ? ratio_of(prescale_ratio_i) : 7'h01; // [RULE7] [RULE4]
	// A runtime ratio change takes effect at once; >= catches a shrinking limit
	assign hit = main_edge_i && ((edge_cnt_q + 7'h01) >= limit); // [RULE5]

	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			edge_cnt_q <= 7'h00;
			periph_level_o <= 1'b0;
			periph_edge_o <= 1'b0;
		end else begin
			periph_edge_o <= hit;
			if (hit) begin
				edge_cnt_q <= 7'h00;
				periph_level_o <= ~periph_level_o;
			end else if (main_edge_i) begin
				edge_cnt_q <= edge_cnt_q + 7'h01;
			end
		end
	end

endmodule

//--- bench/clk_sel_checker.sv
/* Port assertions for the main clock select and prescale block.
   Bound to the top module; sees its ports only. */
`timescale 1ns/1ns
module clk_sel_checker (
	// Clock and reset
	input wire ref_clk_i,
	input wire rst_n_i,
	// Watched ports
	input wire hsel_i,
	input wire [1:0] htrans_i,
	input wire hwrite_i,
	input wire [31:0] hrdata_o,
	input wire ccp_unlock_i,
	input wire [3:0] source_edge_i,
	input wire [4:0] osc_stable_i,
	input wire [4:0] osc_request_o,
	input wire [3:0] main_source_o,
	input wire peripheral_clock_o,
	input wire periph_edge_o,
	input wire clock_pin_o,
	input wire [7:0] pll_control_a_o,
	input wire [7:0] lp_osc_control_a_o,
	input wire [7:0] crystal_osc_control_a_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_pin_follow: assert property (clock_pin_o |-> peripheral_clock_o)
		else $error("pin high with peripheral clock low");
	// A register write reaches the pin three samples after its address phase
	a_pin_stops: assert property ($changed(clock_pin_o) |-> $changed(peripheral_clock_o) ||
		$past(hsel_i && htrans_i[1] && hwrite_i, 3))
		else $error("pin moved without peripheral clock");
	a_source_legal: assert property (main_source_o < 4'h4)
		else $error("main source out of range");
	// Window of three looks back, since edges come at most every other cycle
	a_edge_cause: assert property (periph_edge_o |-> ($past(|source_edge_i, 2) ||
		$past(|source_edge_i, 1) || $past(|source_edge_i, 3)))
		else $error("peripheral toggle without main edge");
	a_upper_zero: assert property (hrdata_o[31:8] == 24'h000000)
		else $error("read data upper bits set");
	a_main_req: assert property (1'b1 |=> osc_request_o[main_source_o])
		else $error("main source not requested");
	a_move_stable: assert property ($changed(main_source_o) |->
		(($past(osc_stable_i, 2) >> main_source_o) & 5'h01) != 5'h00)
		else $error("switched to unstable source");
	a_ccp_guard: assert property ($changed({pll_control_a_o, lp_osc_control_a_o,
		crystal_osc_control_a_o}) |-> $past(ccp_unlock_i))
		else $error("protected register changed without key");
endmodule
bind main_clock_select_prescale clk_sel_checker clk_sel_checker_inst (
	.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
	.hwrite_i(hwrite_i), .hrdata_o(hrdata_o),
	.ccp_unlock_i(ccp_unlock_i), .source_edge_i(source_edge_i),
	.osc_stable_i(osc_stable_i), .osc_request_o(osc_request_o),
	.main_source_o(main_source_o), .peripheral_clock_o(peripheral_clock_o),
	.periph_edge_o(periph_edge_o), .clock_pin_o(clock_pin_o),
	.pll_control_a_o(pll_control_a_o), .lp_osc_control_a_o(lp_osc_control_a_o),
	.crystal_osc_control_a_o(crystal_osc_control_a_o)
);

//--- bench/main_clock_select_prescale_test.sv
/* Self-checking bench for the main clock select and prescale block.
   Assumes an AHB-Lite slave that answers with hreadyout high. */
`timescale 1ns/1ns
module main_clock_select_prescale_test;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic sel = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [1:0] trans = 2'h0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic key = 1'b1;
	logic [3:0] sedge = 4'h0;
	logic [4:0] stab = 5'h00;
	logic [4:0] preq = 5'h00;
	logic pin_q = 1'b0;
	logic [7:0] rv;
	wire [31:0] rdata;
	wire rdy, resp, pclk, pedge, pin;
	wire [4:0] oreq;
	wire [3:0] msrc;
	int bad_count = 0;
	int n_compared = 0;
	int pe_cnt = 0;
	int pin_cnt = 0;

	always #50 clk = ~clk;
	always @(posedge clk) begin
		if (pedge === 1'b1)
			pe_cnt++;
		if (pin !== pin_q)
			pin_cnt++;
		pin_q <= pin;
	end

	main_clock_select_prescale main_clock_select_prescale_inst (
		.ref_clk_i(clk), .rst_n_i(rst_n), .hsel_i(sel), .haddr_i(addr),
		.htrans_i(trans), .hwrite_i(wr), .hsize_i(3'h2), .hwdata_i(wdata),
		.hready_i(rdy), .hrdata_o(rdata), .hreadyout_o(rdy), .hresp_o(resp),
		.ccp_unlock_i(key), .source_edge_i(sedge), .osc_stable_i(stab),
		.periph_request_i(preq), .osc_request_o(oreq), .main_source_o(msrc),
		.peripheral_clock_o(pclk), .periph_edge_o(pedge), .clock_pin_o(pin),
		.hf_osc_control_a_o(), .hf_osc_freq_tune_o(), .pll_control_a_o(),
		.lp_osc_control_a_o(), .crystal_osc_control_a_o()
	);

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chkn(input string n, input int e, input int g);
		n_compared++;
		if (g != e) begin
			bad_count++;
			$display("[ERR] %s expected %0d seen %0d", n, e, g);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge clk);
		sel <= 1'b1;
		addr <= a;
		trans <= 2'h2;
		wr <= w;
		@(posedge clk);
		while (rdy !== 1'b1) @(posedge clk);
		sel <= 1'b0;
		trans <= 2'h0;
		wdata <= {24'h000000, d};
		@(posedge clk);
		while (rdy !== 1'b1) @(posedge clk);
		rv = rdata[7:0];
		chk("response", 8'h00, {7'h00, resp});
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
		bus(a, 1'b0, 8'h00);
		chk(n, e, rv);
	endtask
	// Both edges of a main clock period come as separate pulses
	task automatic edges(input int s, input int n);
		repeat (n) begin
			@(posedge clk);
			sedge[s] <= 1'b1;
			@(posedge clk);
			sedge[s] <= 1'b0;
		end
	endtask
	task automatic results;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic t_reset;
		logic [7:0] a[10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20, 8'h24, 8'h40, 8'h60, 8'h70, 8'h14};
		bus(8'h14, 1'b1, 8'hFF);
		for (int i = 0; i < 10; i++)
			rd(a[i], (i == 4) ? 8'h0C : 8'h00, "reset value");
		$display("reset test done");
	endtask
	task automatic t_div;
		logic [7:0] cb[13] = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h09, 8'h0B, 8'h11, 8'h13,
			8'h15, 8'h17, 8'h19, 8'h0D, 8'h0A};
		int nd[13] = '{2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48, 48, 1};
		int c0;
		int p0;
		key <= 1'b0;
		bus(8'h04, 1'b1, 8'h03);
		rd(8'h04, 8'h00, "keyless write");
		key <= 1'b1;
		bus(8'h00, 1'b1, 8'h80);
		// Window of 960 edges holds a whole number of peripheral half periods for every ratio
		for (int i = 0; i < 13; i++) begin
			bus(8'h04, 1'b1, cb[i]);
			edges(0, 64);
			repeat (4) @(posedge clk);
			c0 = pe_cnt;
			p0 = pin_cnt;
			edges(0, 960);
			repeat (4) @(posedge clk);
			chkn("periph toggles", 960 / nd[i], pe_cnt - c0);
			chkn("pin toggles", 960 / nd[i], pin_cnt - p0);
			chk("pin level", {7'h00, pclk}, {7'h00, pin});
		end
		p0 = pin_cnt;
		repeat (8) @(posedge clk);
		chkn("pin stopped", p0, pin_cnt);
		bus(8'h00, 1'b1, 8'h00);
		repeat (4) @(posedge clk);
		p0 = pin_cnt;
		edges(0, 16);
		chkn("pin disabled", p0, pin_cnt);
		$display("divider test done");
	endtask
	task automatic t_switch;
		stab <= 5'h01;
		bus(8'h00, 1'b1, 8'h02);
		rd(8'h0C, 8'h03, "switch pending");
		chk("main source", 8'h00, {4'h0, msrc});
		stab <= 5'h05;
		repeat (4) @(posedge clk);
		chk("main source", 8'h02, {4'h0, msrc});
		rd(8'h0C, 8'h08, "switch done");
		stab <= 5'h17;
		bus(8'h60, 1'b1, 8'h80);
		rd(8'h0C, 8'h08, "standby only");
		chk("osc requests", 8'h06, {3'h0, oreq});
		preq <= 5'h12;
		rd(8'h0C, 8'h2C, "periph requests");
		preq <= 5'h00;
		bus(8'h00, 1'b1, 8'h07);
		rd(8'h00, 8'h02, "reserved select");
		$display("switch test done");
	endtask
	task automatic t_lock;
		bus(8'h70, 1'b1, 8'h01);
		bus(8'h08, 1'b1, 8'h01);
		bus(8'h04, 1'b1, 8'h03);
		rd(8'h04, 8'h0A, "locked ctrl b");
		bus(8'h00, 1'b1, 8'h00);
		rd(8'h00, 8'h02, "locked ctrl a");
		bus(8'h70, 1'b1, 8'h00);
		rd(8'h70, 8'h01, "locked calib");
		bus(8'h08, 1'b1, 8'h00);
		rd(8'h08, 8'h00, "lock read");
		bus(8'h04, 1'b1, 8'h03);
		rd(8'h04, 8'h0A, "lock kept");
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		bus(8'h04, 1'b1, 8'h03);
		rd(8'h04, 8'h03, "lock released");
		$display("lock test done");
	endtask

	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_div;
		t_switch;
		t_lock;
		results;
	end
	// About three times the expected run length
	initial begin
		#8000000;
		bad_count++;
		results;
	end
endmodule
